/* fxtc_pkg.sv */
// Shared constants and types for the FX to TX media converter
package fxtc_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MDIX_SLOT_NS = 1000;
  localparam int MDIX_SLOT_CYC = (MDIX_SLOT_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int MDIX_CNT_W = 8;

  // Scrambler polynomial x^11 + x^9 + 1
  localparam int LFSR_W = 11;
  localparam int LFSR_TAP_A = 10;
  localparam int LFSR_TAP_B = 8;
  localparam logic [10:0] LFSR_SEED = 11'h000;

  // Buffer shape
  localparam int BUF_W = 1;
  localparam int BUF_DEPTH = 2;

  // Synchroniser bit positions
  localparam int SY_HTX = 0;
  localparam int SY_APOS = 1;
  localparam int SY_ANEG = 2;
  localparam int SY_BPOS = 3;
  localparam int SY_BNEG = 4;
  localparam int SY_INH = 5;
  localparam int SY_PFULL = 6;
  localparam int SY_SCL = 7;
  localparam int SY_SDA = 8;
  localparam int SY_W = 9;
  // Inhibit, clock and data idle high through their pull-ups
  localparam logic [8:0] SY_RST = 9'h1a0;

  // Management serial addresses, bit 0 selects read
  localparam logic [6:0] ID_MEM_ADDR = 7'h50;
  localparam logic [6:0] PHY_ADDR = 7'h5f;
  // Identification byte value is arbitrary
  localparam logic [7:0] ID_FILL_BYTE = 8'hff;

  // PHY register pointers and control layout
  localparam logic [7:0] PHY_PTR_STAT = 8'h00;
  localparam logic [7:0] PHY_PTR_CTRL = 8'h01;
  localparam int CTRL_ADV_FULL = 0;
  localparam int CTRL_ADV_PAUSE = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam logic [3:0] BIT_CNT_FULL = 4'h8;

  // Three level line drive
  typedef struct packed {
    logic pos;
    logic neg;
  } fxtc_line_s;

  typedef enum {
    I2C_IDLE,
    I2C_ADDR,
    I2C_ACK_A,
    I2C_WR,
    I2C_ACK_W,
    I2C_RD,
    I2C_ACK_R
  } fxtc_i2c_e;

endpackage : fxtc_pkg

/* fxtc_buf.sv */
// Two entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module fxtc_buf #(
  parameter int W = fxtc_pkg::BUF_W
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  import fxtc_pkg::*;

  logic [W-1:0] mem [BUF_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  // Full and empty follow the entry count
  assign in_ready_o = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Entry storage
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mem[0] <= '0;
      mem[1] <= '0;
    end
    else if (push)
      mem[wr_ptr] <= in_data_i;
  end

  // Pointers and count
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push && !pop)
        count <= count + 2'h1;
      else if (pop && !push)
        count <= count - 2'h1;
    end
  end

endmodule : fxtc_buf

/* fxtc_top.sv */
// FX serial to TX copper media converter with management slave
// Summary of operation
// R1: Host NRZI transmit stream becomes copper MLT-3
// R2: Copper MLT-3 becomes NRZI to host
// R3: Scramble toward copper, descramble from copper
// R4: Transmit and receive paths run independently
// R5: Half duplex supported alongside full duplex
// R6: Fixed 100 Mb/s; negotiate duplex, pause
// R7: No parallel detection of partner speed
// R8: Automatic pair swap from sensed receive energy
// R9: Inhibit high disables whichever pair transmits
// R10: Inhibit low allows normal transmission
// R11: Undriven inhibit counts as high
// R12: Loss of signal output held low
// R13: Transmit fault output held low
// R14: Bandwidth select input ignored
// R15: Host keeps serial clock under maximum rate
// R16: Serial link: host clock, two-way data
// R17: Module never holds serial clock low
// R18: Identification memory answers its own address
// R19: PHY registers answer at separate address
// R20: MLT-3 steps on ones, holds on zeros
`timescale 1ns/1ps
module fxtc_top (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Host serial pairs
  input wire logic host_tx_pos_i,
  input wire logic host_tx_neg_i,
  output logic host_rx_pos_o,
  output logic host_rx_neg_o,
  // Copper pair A and B drive and sense
  output fxtc_pkg::fxtc_line_s pair_a_tx_o,
  output logic pair_a_oe_o,
  output fxtc_pkg::fxtc_line_s pair_b_tx_o,
  output logic pair_b_oe_o,
  input wire fxtc_pkg::fxtc_line_s pair_a_rx_i,
  input wire fxtc_pkg::fxtc_line_s pair_b_rx_i,
  // Negotiation and link status
  input wire logic link_partner_full_i,
  output logic full_duplex_o,
  output logic pause_adv_o,
  output logic collision_o,
  output logic mdix_swap_o,
  // Host sideband pins
  input wire logic transmit_inhibit_i,
  input wire logic rate_select_i,
  output logic tx_fault_o,
  output logic signal_lost_flag_o,
  // Management serial pins
  input wire logic mgmt_serial_clock_i,
  input wire logic mgmt_serial_data_i,
  output logic mgmt_serial_data_o,
  output logic mgmt_serial_data_oe_o
);
  import fxtc_pkg::*;

  logic [SY_W-1:0] sy_raw;
  logic [SY_W-1:0] sync1;
  logic [SY_W-1:0] sync2;
  logic [SY_W-1:0] sync_d;
  logic [LFSR_W-1:0] scr;
  logic [LFSR_W-1:0] dscr;
  logic tx_bit;
  logic scr_bit;
  logic buf_ready;
  logic buf_valid;
  logic buf_bit;
  logic drain_ready;
  logic [1:0] mlt_idx;
  fxtc_line_s mlt_lvl;
  fxtc_line_s rx_lvl;
  fxtc_line_s rx_prev;
  logic rx_bit;
  logic dscr_bit;
  logic energy;
  logic [MDIX_CNT_W-1:0] idle_cnt;
  logic [1:0] phy_ctrl;
  fxtc_i2c_e st;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] ptr;
  logic [7:0] rd_byte;
  logic sel_phy;
  logic ptr_set;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic next_full_duplex;

  // Two flip-flop synchronisers for every pin input except host_tx_neg_i and rate_select_i
  assign sy_raw = {mgmt_serial_data_i, mgmt_serial_clock_i,
                   link_partner_full_i, transmit_inhibit_i,
                   pair_b_rx_i.neg, pair_b_rx_i.pos,
                   pair_a_rx_i.neg, pair_a_rx_i.pos, host_tx_pos_i};
  for (genvar g = 0; g < SY_W; g++)
  begin : g_sync
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        sync1[g] <= SY_RST[g];
        sync2[g] <= SY_RST[g];
        sync_d[g] <= SY_RST[g];
      end
      else
      begin
        sync1[g] <= sy_raw[g];
        sync2[g] <= sync1[g];
        sync_d[g] <= sync2[g];
      end
    end
  end

  // NRZI decode: a level change is a one; the inverted leg is redundant
  assign tx_bit = sync2[SY_HTX] ^ sync_d[SY_HTX]; // R1
  assign scr_bit = tx_bit ^ scr[LFSR_TAP_A] ^ scr[LFSR_TAP_B]; // R3

  // Self-synchronising scrambler, stalls while the buffer is full
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      scr <= LFSR_SEED;
    else if (buf_ready)
      scr <= {scr[LFSR_W-2:0], scr_bit}; // R3
  end

  // Inhibit drains nothing, so the buffer fills and the scrambler halts
  assign drain_ready = !sync2[SY_INH]; // R10 R11

  fxtc_buf #(
    .W(BUF_W)
  ) u_buf (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(1'b1),
    .in_ready_o(buf_ready),
    .in_data_i(scr_bit),
    .out_valid_o(buf_valid),
    .out_ready_i(drain_ready),
    .out_data_o(buf_bit)
  );

  // MLT-3 cycle zero, plus, zero, minus
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      mlt_idx <= 2'h0;
    else if (buf_valid && drain_ready && buf_bit)
      mlt_idx <= mlt_idx + 2'h1; // R20
  end
  assign mlt_lvl.pos = (mlt_idx == 2'h1);
  assign mlt_lvl.neg = (mlt_idx == 2'h3);

  // Pair routing; the driver of the active pair follows inhibit
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pair_a_tx_o <= '0;
      pair_b_tx_o <= '0;
      pair_a_oe_o <= 1'b0;
      pair_b_oe_o <= 1'b0;
    end
    else
    begin
      pair_a_tx_o <= (mdix_swap_o || sync2[SY_INH]) ? '0 : mlt_lvl; // R1
      pair_b_tx_o <= (!mdix_swap_o && !sync2[SY_INH]) ? '0 : mlt_lvl;
      if (sync2[SY_INH])
        pair_b_tx_o <= '0;
      pair_a_oe_o <= !mdix_swap_o && !sync2[SY_INH]; // R9 R10
      pair_b_oe_o <= mdix_swap_o && !sync2[SY_INH]; // R9
    end
  end

  // Receive pair is the one not transmitting
  assign rx_lvl.pos = mdix_swap_o ? sync2[SY_APOS] : sync2[SY_BPOS];
  assign rx_lvl.neg = mdix_swap_o ? sync2[SY_ANEG] : sync2[SY_BNEG];
  assign energy = rx_lvl.pos || rx_lvl.neg;
  assign rx_bit = (rx_lvl != rx_prev); // R2
  assign dscr_bit = rx_bit ^ dscr[LFSR_TAP_A] ^ dscr[LFSR_TAP_B]; // R3

  // Receive path, independent of transmit
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rx_prev <= '0;
      dscr <= LFSR_SEED;
      host_rx_pos_o <= 1'b0;
      host_rx_neg_o <= 1'b1;
    end
    else
    begin
      rx_prev <= rx_lvl;
      dscr <= {dscr[LFSR_W-2:0], rx_bit}; // R3 R4
      if (dscr_bit)
      begin
        host_rx_pos_o <= ~host_rx_pos_o; // R2
        host_rx_neg_o <= ~host_rx_neg_o;
      end
    end
  end

  // Swap hunt: toggle pairs after a quiet slot; any energy restarts the slot count
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      idle_cnt <= '0;
      mdix_swap_o <= 1'b0;
    end
    else if (energy)
      idle_cnt <= '0;
    else if (idle_cnt == MDIX_CNT_W'(MDIX_SLOT_CYC - 1))
    begin
      idle_cnt <= '0;
      mdix_swap_o <= ~mdix_swap_o; // R8
    end
    else
      idle_cnt <= idle_cnt + 1'b1;
  end

  // Duplex resolution; speed is fixed, no parallel detection (R6 R7)
  // Collision follows the same next value, so it never lags a change
  assign next_full_duplex = phy_ctrl[CTRL_ADV_FULL] && sync2[SY_PFULL];
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      full_duplex_o <= 1'b0;
      pause_adv_o <= 1'b0;
      collision_o <= 1'b0;
    end
    else
    begin
      full_duplex_o <= next_full_duplex; // R6
      pause_adv_o <= phy_ctrl[CTRL_ADV_PAUSE]; // R6
      collision_o <= !next_full_duplex && energy
                     && (mlt_lvl != '0); // R5
    end
  end

  // Tied-off sideband outputs; rate select has no load (R14)
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tx_fault_o <= 1'b0;
      signal_lost_flag_o <= 1'b0;
    end
    else
    begin
      tx_fault_o <= 1'b0; // R13
      signal_lost_flag_o <= 1'b0; // R12
    end
  end

  // Serial bus conditions; clock is input only, never held (R17)
  assign scl_rise = sync2[SY_SCL] && !sync_d[SY_SCL]; // R16
  assign scl_fall = !sync2[SY_SCL] && sync_d[SY_SCL];
  assign start_c = sync2[SY_SCL] && sync_d[SY_SCL] && sync_d[SY_SDA]
                   && !sync2[SY_SDA];
  assign stop_c = sync2[SY_SCL] && sync_d[SY_SCL] && !sync_d[SY_SDA]
                  && sync2[SY_SDA];
  assign rd_byte = !sel_phy ? ID_FILL_BYTE :
                   (ptr == PHY_PTR_CTRL) ? {6'h00, phy_ctrl} :
                   {4'h0, collision_o, mdix_swap_o, full_duplex_o,
                    energy};

  // Serial slave state, bit counting and data drive
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st <= I2C_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      sel_phy <= 1'b0;
      mgmt_serial_data_oe_o <= 1'b0;
    end
    else if (start_c)
    begin
      st <= I2C_ADDR;
      bit_cnt <= 4'h0;
      mgmt_serial_data_oe_o <= 1'b0;
    end
    else if (stop_c)
    begin
      st <= I2C_IDLE;
      mgmt_serial_data_oe_o <= 1'b0;
    end
    else
    begin
      case (st)
        I2C_ADDR, I2C_WR:
        begin
          if (scl_rise && bit_cnt != BIT_CNT_FULL)
          begin
            shreg <= {shreg[6:0], sync2[SY_SDA]};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt == BIT_CNT_FULL)
          begin
            if (st == I2C_WR)
            begin
              st <= I2C_ACK_W;
              mgmt_serial_data_oe_o <= 1'b1;
            end
            else if (shreg[7:1] == ID_MEM_ADDR || shreg[7:1] == PHY_ADDR)
            begin
              st <= I2C_ACK_A; // R18 R19
              sel_phy <= (shreg[7:1] == PHY_ADDR);
              mgmt_serial_data_oe_o <= 1'b1;
            end
            else
              st <= I2C_IDLE;
          end
        end
        I2C_ACK_A, I2C_ACK_W:
        begin
          if (scl_fall)
          begin
            bit_cnt <= 4'h0;
            if (st == I2C_ACK_A && shreg[0])
            begin
              st <= I2C_RD; // R18
              shreg <= {rd_byte[6:0], 1'b0};
              mgmt_serial_data_oe_o <= !rd_byte[7];
            end
            else
            begin
              st <= I2C_WR;
              mgmt_serial_data_oe_o <= 1'b0;
            end
          end
        end
        I2C_RD:
        begin
          if (scl_rise)
            bit_cnt <= bit_cnt + 4'h1;
          else if (scl_fall)
          begin
            if (bit_cnt == BIT_CNT_FULL)
            begin
              st <= I2C_ACK_R;
              mgmt_serial_data_oe_o <= 1'b0;
            end
            else
            begin
              mgmt_serial_data_oe_o <= !shreg[7];
              shreg <= {shreg[6:0], 1'b0};
            end
          end
        end
        I2C_ACK_R:
        begin
          if (scl_rise && sync2[SY_SDA])
            st <= I2C_IDLE;
          else if (scl_fall)
          begin
            st <= I2C_RD;
            bit_cnt <= 4'h0;
            shreg <= {rd_byte[6:0], 1'b0};
            mgmt_serial_data_oe_o <= !rd_byte[7];
          end
        end
        default:
          mgmt_serial_data_oe_o <= 1'b0;
      endcase
    end
  end

  // PHY register pointer and control writes
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ptr <= PHY_PTR_STAT;
      ptr_set <= 1'b0;
      phy_ctrl <= CTRL_RST;
      mgmt_serial_data_o <= 1'b0;
    end
    else
    begin
      mgmt_serial_data_o <= 1'b0; // Open drain: only ever pulls low
      if (st == I2C_ADDR)
        ptr_set <= 1'b0;
      else if (st == I2C_ACK_W && scl_fall && sel_phy)
      begin
        ptr_set <= 1'b1;
        if (!ptr_set)
          ptr <= shreg; // R19
        else if (ptr == PHY_PTR_CTRL)
          phy_ctrl <= shreg[1:0];
      end
    end
  end

  // Checks
  sequence inh_held_s;
    sync2[SY_INH] [*2];
  endsequence
  sequence one_popped_s;
    buf_valid && drain_ready && buf_bit;
  endsequence

  inhibit_off_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    inh_held_s |-> !pair_a_oe_o && !pair_b_oe_o) // R9
    else $error("driver enabled while inhibited");
  inhibit_on_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !sync2[SY_INH] ##1 !sync2[SY_INH] |-> pair_a_oe_o != pair_b_oe_o) // R10
    else $error("no pair driving with inhibit low");
  fault_low_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !tx_fault_o) // R13
    else $error("fault output raised");
  los_low_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !signal_lost_flag_o) // R12
    else $error("loss of signal raised");
  mlt_step_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    one_popped_s |=> mlt_idx == $past(mlt_idx) + 2'h1) // R20
    else $error("level did not step on one");
  mlt_hold_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !(buf_valid && drain_ready && buf_bit) |=> $stable(mlt_idx)) // R20
    else $error("level moved without one");
  swap_slot_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $changed(mdix_swap_o) |-> $past(idle_cnt) ==
      MDIX_CNT_W'(MDIX_SLOT_CYC - 1)) // R8
    else $error("swap outside slot end");
  rx_nrzi_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    dscr_bit |=> host_rx_pos_o != $past(host_rx_pos_o)
      && host_rx_neg_o == !host_rx_pos_o) // R2
    else $error("receive stream not toggled");
  duplex_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    full_duplex_o |-> !collision_o) // R5
    else $error("collision in full duplex");
  addr_miss_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    st == I2C_IDLE ##1 st == I2C_IDLE |-> !mgmt_serial_data_oe_o) // R18
    else $error("data driven while idle");

endmodule : fxtc_top

/* fxtc_host_model.sv */
// Host PHY model: NRZI transmit pair and two-wire master
`timescale 1ns/1ps
module fxtc_host_model (
  // Clock
  input wire logic sys_clk_i,
  // One stream bit per clock, one means a line toggle
  input wire logic tx_bit_i,
  // Host transmit pair
  output logic host_tx_pos_o,
  output logic host_tx_neg_o,
  // Two-wire clock and open-drain data
  output logic scl_o,
  inout wire logic sda_io
);
  // Quarter of a 10 us bit, so the clock never beats 100 kHz
  localparam int QTR = 312;
  logic sda_low = 1'b0;

  initial scl_o = 1'b1;
  // Data is only ever pulled low; the pull-up gives the high
  assign sda_io = sda_low ? 1'b0 : 1'bz;
  assign host_tx_neg_o = ~host_tx_pos_o;

  // NRZI: a one flips the line, a zero holds it
  initial host_tx_pos_o = 1'b0;
  always @(posedge sys_clk_i)
    if (tx_bit_i)
      host_tx_pos_o <= #1 ~host_tx_pos_o;

  task automatic wait_q(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : wait_q

  // Start: data falls while the clock is high
  task automatic i2c_start();
    sda_low = 1'b0;
    scl_o = 1'b1;
    wait_q(QTR);
    sda_low = 1'b1;
    wait_q(QTR);
    scl_o = 1'b0;
    wait_q(QTR);
  endtask : i2c_start

  // Stop: data rises while the clock is high
  task automatic i2c_stop();
    sda_low = 1'b1;
    wait_q(QTR);
    scl_o = 1'b1;
    wait_q(QTR);
    sda_low = 1'b0;
    wait_q(QTR);
  endtask : i2c_stop

  // Eight bits and the acknowledge slot, first bit first
  task automatic i2c_xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      sda_low = ~tx[i];
      wait_q(QTR);
      scl_o = 1'b1;
      wait_q(QTR);
      rx[i] = sda_io;
      wait_q(QTR + 1);
      scl_o = 1'b0;
      wait_q(QTR + 1);
    end
  endtask : i2c_xfer
endmodule : fxtc_host_model

/* fxtc_tb.sv */
// Self-checking bench for the FX to TX media converter
`timescale 1ns/1ps
module tb;
  import fxtc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic tx_bit, tx_run, rx_run, inh_en, inh_val, rate_sel, pfull;
  logic scl, htx_p, htx_n, hrx_p, hrx_n, a_oe, b_oe, fdx, pause;
  logic coll, swap, fault, signal_lost_flag, sda_do, sda_oe, r, s, sw0;
  logic tx_chk, rx_chk, coll_seen, hq;
  fxtc_line_s a_tx, b_tx, a_rx, b_rx, tl, tl_q;
  logic [10:0] rs = 11'h000;
  logic [10:0] ts = 11'h000;
  logic [1:0] ri = 2'h0;
  logic [1:0] ti = 2'h0;
  logic [8:0] rb;
  logic [7:0] wr [3];
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  int rj = 0;
  int tg = 0;
  int tj = -1;
  int hj = -1;
  int n;
  // Inhibit and data lines idle high through their pull-ups
  tri1 inh_w, sda_w;

  assign inh_w = inh_en ? inh_val : 1'bz;
  assign sda_w = (sda_oe && !sda_do) ? 1'b0 : 1'bz;
  always #4 sys_clk_i = ~sys_clk_i;

  fxtc_top uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .host_tx_pos_i(htx_p), .host_tx_neg_i(htx_n), .host_rx_pos_o(hrx_p),
    .host_rx_neg_o(hrx_n), .pair_a_tx_o(a_tx), .pair_a_oe_o(a_oe),
    .pair_b_tx_o(b_tx), .pair_b_oe_o(b_oe), .pair_a_rx_i(a_rx),
    .pair_b_rx_i(b_rx), .link_partner_full_i(pfull), .full_duplex_o(fdx),
    .pause_adv_o(pause), .collision_o(coll), .mdix_swap_o(swap),
    .transmit_inhibit_i(inh_w), .rate_select_i(rate_sel),
    .tx_fault_o(fault), .signal_lost_flag_o(signal_lost_flag),
    .mgmt_serial_clock_i(scl), .mgmt_serial_data_i(sda_w),
    .mgmt_serial_data_o(sda_do), .mgmt_serial_data_oe_o(sda_oe));

  fxtc_host_model host (.sys_clk_i(sys_clk_i), .tx_bit_i(tx_bit),
    .host_tx_pos_o(htx_p), .host_tx_neg_o(htx_n), .scl_o(scl),
    .sda_io(sda_w));

  // Three-level line for a step index: 0, +, 0, -
  function automatic fxtc_line_s lvl(input logic [1:0] i);
    return (i == 2'h1) ? fxtc_line_s'(2'h2) :
           (i == 2'h3) ? fxtc_line_s'(2'h1) : fxtc_line_s'(2'h0);
  endfunction : lvl

  // Test data: a busy burst of 160 bits, then zeros
  function automatic logic pat(input int j, input int k);
    return (j < 160) && (((j * k) % 11) < 4);
  endfunction : pat

  task automatic chk(input logic c, input string msg);
    total_checks++;
    if (c !== 1'b1)
    begin
      mismatches++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask : chk

  task automatic wait_c(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask : wait_c

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // Stimulus: host stream bits, and a scrambled MLT-3 copper receive
  // line on both pairs so the swap cannot change what is received
  always @(posedge sys_clk_i)
  begin
    if (tx_run)
    begin
      tx_bit <= #1 pat(tg, 5);
      tg++;
    end
    if (rx_run)
    begin
      r = pat(rj, 3) ^ rs[LFSR_TAP_A] ^ rs[LFSR_TAP_B];
      rs = {rs[9:0], r};
      ri = ri + {1'b0, r};
      rj++;
      a_rx <= #1 lvl(ri);
      b_rx <= #1 lvl(ri);
    end
  end

  // Monitors, aligned on the first step so latency is free
  always @(posedge sys_clk_i)
  begin
    tl = swap ? b_tx : a_tx;
    if (tx_chk && tj < 250 && (tj >= 0 || tl !== tl_q))
    begin
      tj++;
      s = pat(tj, 5) ^ ts[LFSR_TAP_A] ^ ts[LFSR_TAP_B];
      ts = {ts[9:0], s};
      ti = ti + {1'b0, s};
      chk(tl === lvl(ti), "copper level");
    end
    tl_q = tl;
    if (rx_chk && hj < 250 && (hj >= 0 || hrx_p !== hq))
    begin
      hj++;
      chk((hrx_p ^ hq) === pat(hj, 3), "host rx bit");
      chk(hrx_n === ~hrx_p, "host rx pair");
    end
    hq = hrx_p;
    if (coll === 1'b1)
      coll_seen = 1'b1;
  end

  // Hang guard; the tests need about 73700 cycles
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      mismatches++;
      $display("MISMATCH t=%0t timeout", $time);
      finish_test();
    end
  end

  // Main sequence
  initial
  begin
    {tx_bit, tx_run, rx_run, inh_en, inh_val, rate_sel} = 6'h00;
    {tx_chk, rx_chk, coll_seen, hq} = 4'h0;
    pfull = 1'b1;
    a_rx = '0;
    b_rx = '0;
    tl_q = '0;
    wr = '{8'hbe, PHY_PTR_CTRL, 8'h00};
    wait_c(2);
    nrst_i = 1'b1;
    wait_c(5);
    chk(fault === 1'b0, "fault");
    chk(signal_lost_flag === 1'b0, "lost");
    chk({a_oe, b_oe} === 2'b00, "open inhibit");
    chk({hrx_p, hrx_n} === 2'b01, "rx idle");
    chk({fdx, pause} === 2'b11, "advert");
    // Silent pairs: swap hunts at a fixed slot
    for (int k = 0; k < 2; k++)
    begin
      sw0 = swap;
      n = 0;
      while (swap === sw0 && n < 200)
      begin
        wait_c(1);
        n++;
      end
    end
    chk(n == MDIX_SLOT_CYC, "swap slot");
    chk({a_oe, b_oe} === 2'b00, "inhibit on swap");
    // Full traffic both ways, half duplex, ignored select toggled
    rate_sel = 1'b1;
    pfull = 1'b0;
    rx_run = 1'b1;
    rx_chk = 1'b1;
    wait_c(20);
    inh_en = 1'b1;
    wait_c(6);
    chk((swap ? {b_oe, a_oe} : {a_oe, b_oe}) === 2'b10, "tx pair");
    chk(fdx === 1'b0, "half duplex");
    tx_chk = 1'b1;
    tx_run = 1'b1;
    wait_c(150);
    rate_sel = 1'b0;
    wait_c(150);
    chk(tj == 250 && hj == 250, "both streams");
    chk(coll_seen === 1'b1, "collision");
    // Inhibit in mid-stream silences whichever pair transmits
    inh_val = 1'b1;
    wait_c(5);
    chk({a_oe, b_oe, a_tx, b_tx} === 6'h00, "inhibit");
    inh_val = 1'b0;
    wait_c(5);
    chk((a_oe | b_oe) === 1'b1, "resume");
    {tx_run, rx_run, tx_bit} = 3'h0;
    wait_c(2);
    pfull = 1'b1;
    wait_c(4);
    chk(fdx === 1'b1, "full duplex");
    // Identification read, then a foreign address
    host.i2c_start();
    host.i2c_xfer({ID_MEM_ADDR, 1'b1, 1'b1}, rb);
    chk(rb[0] === 1'b0, "id ack");
    host.i2c_xfer(9'h1ff, rb);
    chk(rb[8:1] === ID_FILL_BYTE, "id byte");
    host.i2c_stop();
    host.i2c_start();
    host.i2c_xfer({8'ha4, 1'b1}, rb);
    chk(rb[0] === 1'b1, "no ack");
    host.i2c_stop();
    // Clear both advert bits through the PHY write address
    host.i2c_start();
    foreach (wr[k])
    begin
      host.i2c_xfer({wr[k], 1'b1}, rb);
      chk(rb[0] === 1'b0, "phy ack");
    end
    host.i2c_stop();
    wait_c(4);
    chk({pause, fdx, sda_oe} === 3'h0, "advert off");
    finish_test();
  end
endmodule : tb
